// >>> core/fhr_pkg.sv
package fhr_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned TRAIN_LIMIT_US = 20_000;
  localparam int unsigned CFG_LIMIT_US = 100_000;
  localparam int unsigned TRAIN_LIMIT_CYC = TRAIN_LIMIT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned CFG_LIMIT_CYC = CFG_LIMIT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned MSMB_SLOW_KHZ = 100;
  localparam int unsigned MSMB_FAST_KHZ = 400;

  // ****************************************
  // Boot vector and modes
  // ****************************************
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_EEPROM = 3'h1;
  localparam int unsigned SADDR_W = 7;
  localparam logic [6:0] SADDR_BASE = 7'h40;
  localparam int unsigned SADDR_B5 = 5;
  localparam int unsigned SADDR_B3 = 3;
  localparam int unsigned SADDR_B2 = 2;
  localparam int unsigned SADDR_B1 = 1;
  localparam int unsigned EE_ERR_W = 8;
  localparam int unsigned PORTS = 4;

  typedef struct packed {
    logic [2:0] mode;
    logic slowSmb;
    logic haltPin;
    logic [3:0] saddrPins;
  } fhr_boot_s;

  localparam fhr_boot_s BOOT_RST = '{mode: 3'h0, slowSmb: 1'b0, haltPin: 1'b0,
                                     saddrPins: 4'h0};

  typedef enum logic [9:0] {
    ST_FUND = 10'h001,
    ST_PLL  = 10'h002,
    ST_SSMB = 10'h004,
    ST_MSMB = 10'h008,
    ST_EE   = 10'h010,
    ST_CHK  = 10'h020,
    ST_HALT = 10'h040,
    ST_RUN  = 10'h080,
    ST_CPL  = 10'h100,
    ST_HOTR = 10'h200
  } fhr_state_e;

  typedef struct packed {
    logic pllRstN;
    logic linkTrainEn;
    logic stackRstN;
    logic stackQuasi;
    logic coreRstN;
    logic slvSmbRstN;
    logic mstSmbRstN;
    logic eeLoadStart;
    logic haltCtl;
    logic haltSts;
    logic eeDone;
    logic [7:0] eeErr;
    logic dsHotTs1;
    logic regRstN;
    logic stickyRstN;
    logic regHotHold;
    logic cfgCplOk;
    logic upRetrainDetect;
    logic [3:0] portRetrain;
    logic eeAccessEn;
    logic gpioForceIn;
  } fhr_out_s;

  localparam fhr_out_s OUT_RST = '{pllRstN: 1'b0, linkTrainEn: 1'b0, stackRstN: 1'b0,
    stackQuasi: 1'b0, coreRstN: 1'b0, slvSmbRstN: 1'b0, mstSmbRstN: 1'b0,
    eeLoadStart: 1'b0, haltCtl: 1'b0, haltSts: 1'b0, eeDone: 1'b0, eeErr: 8'h00,
    dsHotTs1: 1'b0, regRstN: 1'b0, stickyRstN: 1'b0, regHotHold: 1'b1, cfgCplOk: 1'b0,
    upRetrainDetect: 1'b0, portRetrain: 4'h0, eeAccessEn: 1'b0, gpioForceIn: 1'b1};

endpackage

// >>> core/fhr_ctl_if.sv
`timescale 1ns/1ps
interface fhr_ctl_if;
  logic pinRelLvl;
  logic tmrClr;
  logic tmrExpired;
  modport sync (output pinRelLvl);
  modport tmr (input tmrClr, output tmrExpired);
  modport seq (input pinRelLvl, input tmrExpired, output tmrClr);
endinterface

// >>> core/fhr_pin_sync.sv
`timescale 1ns/1ps
module fhr_pin_sync (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic fundResetInN,
  fhr_ctl_if.sync ctl
);
  logic meta_r;
  logic meta_nxt;
  logic lvl_r;
  logic lvl_nxt;

  always_comb begin
    meta_nxt = fundResetInN;
    lvl_nxt = meta_r;
  end

  // Held in reset state until two edges see the pin released
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      meta_r <= 1'b0;
      lvl_r <= 1'b0;
    end else if (clkEn) begin
      meta_r <= meta_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  assign ctl.pinRelLvl = lvl_r;
endmodule

// >>> core/fhr_deadline_tmr.sv
`timescale 1ns/1ps
module fhr_deadline_tmr #(
  parameter int unsigned LIMIT_CYC = 2_500_000
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clkEn,
  fhr_ctl_if.tmr ctl
);
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic exp_r;
  logic exp_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    exp_nxt = exp_r;
    if (ctl.tmrClr) begin
      cnt_nxt = 32'h0;
      exp_nxt = 1'b0;
    end else if (!exp_r) begin
      cnt_nxt = cnt_r + 32'h1;
      exp_nxt = (cnt_r + 32'h1 >= 32'(LIMIT_CYC - 1));
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cnt_r <= 32'h0;
      exp_r <= 1'b0;
    end else if (clkEn) begin
      cnt_r <= cnt_nxt;
      exp_r <= exp_nxt;
    end
  end

  assign ctl.tmrExpired = exp_r;
endmodule

// >>> core/fhr_reset_seq.sv
`timescale 1ns/1ps
// Functional notes
// - Reset pin or warm request starts fundamental reset
// - Sample boot on pin release, else reuse
// - Decode mode; value one means EEPROM load
// - PLL lock, then training, sequence continues
// - Halt pin sets status halt bit
// - Stacks quasi-reset; training within 20 ms
// - Config retry within 100 ms; others ignored (no 100 ms limit here: retry held until core reset release)
// - Slow select picks 100 kHz master SMBus
// - Slave SMBus with pin address, then master
// - EEPROM load; loaded retrain bit retrains port
// - EEPROM error aborts, sets halt, records error
// - Set EEPROM done, then check halt bit
// - Halt holds logic until SMBus clears it
// - While halted, registers and EEPROM reachable
// - General-purpose pins forced to inputs on reset
// - Hot reset from TS1, link down, or request
// - Hot reset: downstream TS1, logic reset
// - Hot reset spares sticky and unlocked fields
// - Hot reload only in EEPROM mode, skip clear
// - Hot-held registers read zero, ignore writes
// - Hot request completes, then upstream full retrain
// - Modes zero and one valid, rest reserved
// - Captured boot values readable in status
module fhr_reset_seq
  import fhr_pkg::*;
#(
  parameter int unsigned TRAIN_CYC = TRAIN_LIMIT_CYC
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic fundResetInN,
  input wire logic warmResetRequestBit,
  input wire logic hotResetRequestBit,
  input wire logic upHotTs1Rx,
  input wire logic upDlDown,
  input wire logic linkdownHotResetDisable,
  input wire logic hotResetEepromSkip,
  input wire logic [2:0] operatingModePins,
  input wire logic haltAfterReset,
  input wire logic masterSmbusSlowSelect,
  input wire logic [3:0] slaveSmbusAddrPins,
  input wire logic pllLock,
  input wire logic eeLoadFinish,
  input wire logic eeLoadErr,
  input wire logic [EE_ERR_W-1:0] eeErrCode,
  input wire logic [PORTS-1:0] eeFullRetrainWr,
  input wire logic haltClear,
  output logic pllSerdesRstN,
  output logic linkTrainEn,
  output logic stackRstN,
  output logic stackCfgRetry,
  output logic coreRstN,
  output logic slaveSmbusRstN,
  output logic masterSmbusRstN,
  output logic masterSmbusSlow,
  output logic [SADDR_W-1:0] slaveSmbusAddr,
  output logic eeLoadStart,
  output logic haltCtlBit,
  output logic haltStsBit,
  output logic eepromLoadDone,
  output logic [EE_ERR_W-1:0] eeErrStatus,
  output logic [2:0] bootMode,
  output logic bootEeMode,
  output logic [8:0] bootStatus,
  output logic dsHotResetTs1,
  output logic regRstN,
  output logic stickyRstN,
  output logic regHotHold,
  output logic cfgWrCplOk,
  output logic upRetrainDetect,
  output logic [PORTS-1:0] portFullRetrain,
  output logic eeAccessEn,
  output logic gpioForceInput
);

  // ****************************************
  // Helpers
  // ****************************************
  fhr_ctl_if ctl ();

  fhr_pin_sync u_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clkEn(clkEn),
    .fundResetInN(fundResetInN),
    .ctl(ctl.sync)
  );

  fhr_deadline_tmr #(
    .LIMIT_CYC(TRAIN_CYC)
  ) u_tmr (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clkEn(clkEn),
    .ctl(ctl.tmr)
  );

  // ****************************************
  // State
  // ****************************************
  fhr_state_e st_r;
  fhr_state_e st_nxt;
  fhr_out_s o_r;
  fhr_out_s o_nxt;
  fhr_boot_s boot_r;
  fhr_boot_s boot_nxt;
  logic fromPin_r;
  logic fromPin_nxt;
  logic hotFlow_r;
  logic hotFlow_nxt;
  logic pendWarm_r;
  logic pendWarm_nxt;
  logic bootEe_r;
  logic bootEe_nxt;
  logic tmrClr;
  logic validMode;
  logic eeMode;
  logic hotEvent;

  always_comb begin
    validMode = (boot_r.mode == MODE_NORMAL) || (boot_r.mode == MODE_EEPROM);
    eeMode = (boot_r.mode == MODE_EEPROM);
    hotEvent = upHotTs1Rx || (upDlDown && !linkdownHotResetDisable);
  end

  always_comb begin
    st_nxt = st_r;
    o_nxt = o_r;
    boot_nxt = boot_r;
    fromPin_nxt = fromPin_r;
    hotFlow_nxt = hotFlow_r;
    pendWarm_nxt = pendWarm_r;
    tmrClr = 1'b0;
    o_nxt.eeLoadStart = 1'b0;
    o_nxt.cfgCplOk = 1'b0;
    o_nxt.upRetrainDetect = 1'b0;
    o_nxt.portRetrain = '0;
    o_nxt.regRstN = 1'b1;
    o_nxt.stickyRstN = 1'b1;
    if (haltClear) begin
      o_nxt.haltCtl = 1'b0;
    end
    case (st_r)
      ST_RUN: begin
        if (warmResetRequestBit || hotResetRequestBit) begin
          o_nxt.cfgCplOk = 1'b1;
          pendWarm_nxt = warmResetRequestBit;
          st_nxt = ST_CPL;
        end else if (hotEvent) begin
          st_nxt = ST_HOTR;
        end
      end
      ST_CPL: begin
        if (pendWarm_r) begin
          fromPin_nxt = 1'b0;
          st_nxt = ST_FUND;
        end else begin
          o_nxt.upRetrainDetect = 1'b1;
          st_nxt = ST_HOTR;
        end
      end
      ST_FUND: begin
        if (fromPin_r) begin
          boot_nxt = '{mode: operatingModePins, slowSmb: masterSmbusSlowSelect,
                       haltPin: haltAfterReset, saddrPins: slaveSmbusAddrPins};
        end
        o_nxt.pllRstN = 1'b1;
        o_nxt.gpioForceIn = 1'b0;
        hotFlow_nxt = 1'b0;
        tmrClr = 1'b1;
        st_nxt = ST_PLL;
      end
      ST_PLL: begin
        if (pllLock || ctl.tmrExpired) begin
          o_nxt.linkTrainEn = 1'b1;
          if (haltAfterReset) begin
            o_nxt.haltSts = 1'b1;
            o_nxt.haltCtl = 1'b1;
          end
          o_nxt.stackRstN = validMode;
          o_nxt.stackQuasi = validMode;
          st_nxt = ST_SSMB;
        end
      end
      ST_SSMB: begin
        o_nxt.slvSmbRstN = 1'b1;
        st_nxt = ST_MSMB;
      end
      ST_MSMB: begin
        o_nxt.mstSmbRstN = 1'b1;
        if (eeMode && !(hotFlow_r && hotResetEepromSkip)) begin
          o_nxt.eeLoadStart = 1'b1;
          o_nxt.eeDone = 1'b0;
          st_nxt = ST_EE;
        end else begin
          st_nxt = ST_CHK;
        end
      end
      ST_EE: begin
        o_nxt.portRetrain = eeFullRetrainWr;
        if (eeLoadFinish) begin
          o_nxt.eeDone = 1'b1;
          if (eeLoadErr) begin
            o_nxt.haltCtl = 1'b1;
            o_nxt.eeErr = eeErrCode;
          end
          st_nxt = ST_CHK;
        end
      end
      ST_CHK: begin
        if (o_r.haltCtl) begin
          o_nxt.eeAccessEn = 1'b1;
          st_nxt = ST_HALT;
        end else begin
          o_nxt.coreRstN = 1'b1;
          o_nxt.stackQuasi = 1'b0;
          o_nxt.regHotHold = 1'b0;
          st_nxt = ST_RUN;
        end
      end
      ST_HALT: begin
        if (!o_nxt.haltCtl) begin
          o_nxt.eeAccessEn = 1'b0;
          o_nxt.coreRstN = 1'b1;
          o_nxt.stackQuasi = 1'b0;
          o_nxt.regHotHold = 1'b0;
          st_nxt = ST_RUN;
        end
      end
      ST_HOTR: begin
        if (!o_r.dsHotTs1) begin
          o_nxt.dsHotTs1 = 1'b1;
          o_nxt.coreRstN = 1'b0;
          o_nxt.stackRstN = 1'b0;
          o_nxt.stackQuasi = 1'b0;
          o_nxt.linkTrainEn = 1'b0;
          o_nxt.regRstN = 1'b0;
          o_nxt.regHotHold = 1'b1;
          hotFlow_nxt = 1'b1;
        end else if (!hotEvent) begin
          o_nxt.dsHotTs1 = 1'b0;
          o_nxt.linkTrainEn = 1'b1;
          o_nxt.stackRstN = validMode;
          o_nxt.stackQuasi = validMode;
          st_nxt = ST_MSMB;
        end
      end
      default: begin
        st_nxt = ST_FUND;
      end
    endcase
    if (!ctl.pinRelLvl) begin
      o_nxt = OUT_RST;
      fromPin_nxt = 1'b1;
      hotFlow_nxt = 1'b0;
      st_nxt = ST_FUND;
    end else if (st_r == ST_CPL && pendWarm_r) begin
      o_nxt = OUT_RST;
      o_nxt.upRetrainDetect = 1'b0;
    end
    bootEe_nxt = (boot_nxt.mode == MODE_EEPROM);
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st_r <= ST_FUND;
      o_r <= OUT_RST;
      boot_r <= BOOT_RST;
      fromPin_r <= 1'b1;
      hotFlow_r <= 1'b0;
      pendWarm_r <= 1'b0;
      bootEe_r <= 1'b0;
    end else if (clkEn) begin
      st_r <= st_nxt;
      o_r <= o_nxt;
      boot_r <= boot_nxt;
      fromPin_r <= fromPin_nxt;
      hotFlow_r <= hotFlow_nxt;
      pendWarm_r <= pendWarm_nxt;
      bootEe_r <= bootEe_nxt;
    end
  end

  assign ctl.tmrClr = tmrClr;

  // ****************************************
  // Outputs
  // ****************************************
  always_comb begin
    slaveSmbusAddr = SADDR_BASE;
    slaveSmbusAddr[SADDR_B5] = boot_r.saddrPins[3];
    slaveSmbusAddr[SADDR_B3] = boot_r.saddrPins[2];
    slaveSmbusAddr[SADDR_B2] = boot_r.saddrPins[1];
    slaveSmbusAddr[SADDR_B1] = boot_r.saddrPins[0];
  end

  assign pllSerdesRstN = o_r.pllRstN;
  assign linkTrainEn = o_r.linkTrainEn;
  assign stackRstN = o_r.stackRstN;
  assign stackCfgRetry = o_r.stackQuasi;
  assign coreRstN = o_r.coreRstN;
  assign slaveSmbusRstN = o_r.slvSmbRstN;
  assign masterSmbusRstN = o_r.mstSmbRstN;
  assign masterSmbusSlow = boot_r.slowSmb;
  assign eeLoadStart = o_r.eeLoadStart;
  assign haltCtlBit = o_r.haltCtl;
  assign haltStsBit = o_r.haltSts;
  assign eepromLoadDone = o_r.eeDone;
  assign eeErrStatus = o_r.eeErr;
  assign bootMode = boot_r.mode;
  assign bootEeMode = bootEe_r;
  assign bootStatus = boot_r;
  assign dsHotResetTs1 = o_r.dsHotTs1;
  assign regRstN = o_r.regRstN;
  assign stickyRstN = o_r.stickyRstN;
  assign regHotHold = o_r.regHotHold;
  assign cfgWrCplOk = o_r.cfgCplOk;
  assign upRetrainDetect = o_r.upRetrainDetect;
  assign portFullRetrain = o_r.portRetrain;
  assign eeAccessEn = o_r.eeAccessEn;
  assign gpioForceInput = o_r.gpioForceIn;
endmodule

// >>> tb/fhr_reset_seq_properties.sv
`timescale 1ns/1ps
module fhr_reset_seq_properties
  import fhr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic fundResetInN,
  input wire logic warmResetRequestBit,
  input wire logic hotResetRequestBit,
  input wire logic masterSmbusSlowSelect,
  input wire logic eeLoadFinish,
  input wire logic eeLoadErr,
  input wire logic [EE_ERR_W-1:0] eeErrCode,
  input wire logic pllSerdesRstN,
  input wire logic stackRstN,
  input wire logic stackCfgRetry,
  input wire logic coreRstN,
  input wire logic slaveSmbusRstN,
  input wire logic masterSmbusRstN,
  input wire logic masterSmbusSlow,
  input wire logic [SADDR_W-1:0] slaveSmbusAddr,
  input wire logic haltCtlBit,
  input wire logic eepromLoadDone,
  input wire logic [EE_ERR_W-1:0] eeErrStatus,
  input wire logic [8:0] bootStatus,
  input wire logic dsHotResetTs1,
  input wire logic regRstN,
  input wire logic stickyRstN,
  input wire logic regHotHold,
  input wire logic cfgWrCplOk,
  input wire logic upRetrainDetect,
  input wire logic eeAccessEn,
  input wire logic gpioForceInput
);
  // ****
  // Checks
  // ****
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn || !clkEn);
  pin_reset_a: assert property ($fell(fundResetInN) |-> ##[1:4]
    (gpioForceInput && !pllSerdesRstN && !stickyRstN)) else $error("pin reset not taken");
  warm_cpl_a: assert property ($rose(warmResetRequestBit) && coreRstN |=> cfgWrCplOk
    ##1 (gpioForceInput && !coreRstN)) else $error("warm completion order wrong");
  hot_cpl_a: assert property ($rose(hotResetRequestBit) && !warmResetRequestBit && coreRstN
    |=> cfgWrCplOk ##1 upRetrainDetect) else $error("hot completion order wrong");
  hot_entry_a: assert property ($rose(dsHotResetTs1) |-> !regRstN && regHotHold
    && !coreRstN && !stackRstN) else $error("hot reset entry wrong");
  hot_spare_a: assert property (dsHotResetTs1 |-> stickyRstN && pllSerdesRstN
    && slaveSmbusRstN && masterSmbusRstN) else $error("hot reset touched spared logic");
  smb_order_a: assert property ($rose(masterSmbusRstN) |-> $past(slaveSmbusRstN))
    else $error("master bus before slave");
  smb_speed_a: assert property ($rose(pllSerdesRstN) && !$past(fundResetInN, 4)
    |-> masterSmbusSlow == $past(masterSmbusSlowSelect)) else $error("master bus speed wrong");
  boot_reuse_a: assert property ($rose(pllSerdesRstN) && $past(fundResetInN, 4)
    |-> $stable(bootStatus)) else $error("boot values not reused");
  slave_addr_a: assert property (slaveSmbusRstN |-> slaveSmbusAddr == (SADDR_BASE
    | {1'b0, bootStatus[3], 1'b0, bootStatus[2:0], 1'b0})) else $error("slave address wrong");
  ee_error_a: assert property (eeLoadFinish && eeLoadErr && masterSmbusRstN && !coreRstN
    && !eepromLoadDone |=> haltCtlBit && eepromLoadDone && eeErrStatus == $past(eeErrCode))
    else $error("load error not recorded");
  ee_done_a: assert property ($rose(eepromLoadDone) |-> ##[1:2]
    (haltCtlBit ? eeAccessEn : coreRstN)) else $error("halt check after load wrong");
  halt_hold_a: assert property (eeAccessEn |-> haltCtlBit && !coreRstN && slaveSmbusRstN
    && masterSmbusRstN && stackCfgRetry) else $error("halt state wrong");
  cover property (eeAccessEn);
  cover property ($rose(dsHotResetTs1));
  cover property (cfgWrCplOk ##1 gpioForceInput);
endmodule

bind fhr_reset_seq fhr_reset_seq_properties props (.*);

// >>> tb/fhr_board_model.sv
`timescale 1ns/1ps
module fhr_board_model (
  input wire logic sys_clk,
  input wire logic pllSerdesRstN,
  input wire logic eeLoadStart,
  input wire logic [7:0] lockDelay,
  input wire logic errInject,
  output logic pllLock,
  output logic eeLoadFinish,
  output logic eeLoadErr,
  output logic [7:0] eeErrCode,
  output logic [3:0] eeFullRetrainWr
);
  localparam int EE_LEN = 12;
  int lockCnt = 0;
  int eeCnt = 0;
  // ****
  // PLL and EEPROM agent
  // ****
  always @(posedge sys_clk) begin
    lockCnt <= pllSerdesRstN ? lockCnt + 1 : 0;
    pllLock <= pllSerdesRstN && lockCnt >= lockDelay;
    eeCnt <= eeLoadStart ? 1 : (eeCnt != 0 && eeCnt < EE_LEN) ? eeCnt + 1 : 0;
    eeFullRetrainWr <= (eeCnt == 4) ? 4'h2 : 4'h0;
    eeLoadFinish <= eeCnt == EE_LEN;
    // Code only valid with finish
    eeLoadErr <= (eeCnt == EE_LEN) ? errInject : ~errInject;
    eeErrCode <= (eeCnt == EE_LEN) ? 8'h5a : 8'ha5;
  end
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import fhr_pkg::*;
;
  logic sys_clk, resetn, clkEn, fundResetInN, warmResetRequestBit, hotResetRequestBit;
  logic upHotTs1Rx, upDlDown, linkdownHotResetDisable, hotResetEepromSkip, haltAfterReset;
  logic masterSmbusSlowSelect, pllLock, eeLoadFinish, eeLoadErr, haltClear, errInject;
  logic [2:0] operatingModePins, bootMode;
  logic [3:0] slaveSmbusAddrPins, eeFullRetrainWr, portFullRetrain;
  logic [7:0] eeErrCode, eeErrStatus, lockDelay;
  logic [8:0] bootStatus;
  logic [6:0] slaveSmbusAddr;
  logic pllSerdesRstN, linkTrainEn, stackRstN, stackCfgRetry, coreRstN, slaveSmbusRstN;
  logic masterSmbusRstN, masterSmbusSlow, eeLoadStart, haltCtlBit, haltStsBit, eepromLoadDone;
  logic bootEeMode, dsHotResetTs1, regRstN, stickyRstN, regHotHold, cfgWrCplOk;
  logic upRetrainDetect, eeAccessEn, gpioForceInput;
  int fail_count = 0, num_checks = 0, cycles = 0, eeStarts = 0, retrains = 0, cpls = 0, hots = 0;

`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, a, b); fail_count++; end end

  fhr_reset_seq #(.TRAIN_CYC(50)) dut (.*);
  fhr_board_model board (.*);

  always #4 sys_clk = ~sys_clk;

  // ****
  // Event counters and timeout
  // ****
  always @(posedge sys_clk) begin
    cycles++;
    eeStarts += int'(eeLoadStart === 1'b1);
    retrains += int'(portFullRetrain === 4'h2);
    cpls += int'(cfgWrCplOk === 1'b1);
    hots += int'(regRstN === 1'b0 && stickyRstN === 1'b1);
    if (cycles == 20000) begin
      fail_count++;
      summarize();
    end
  end

  task automatic summarize;
    if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask

  // Wait for run or halt
  task automatic settle;
    int i;
    cyc(4);
    for (i = 0; i < 300 && coreRstN !== 1'b1 && eeAccessEn !== 1'b1; i++) cyc(1);
    `CHK(coreRstN | eeAccessEn, 1'b1)
  endtask

  task automatic boot(input logic [2:0] m, input logic s, h, input logic [3:0] a);
    {operatingModePins, masterSmbusSlowSelect, haltAfterReset, slaveSmbusAddrPins} = {m, s, h, a};
    fundResetInN = 1'b0;
    cyc(4);
    fundResetInN = 1'b1;
    settle();
    `CHK(bootStatus, {m, s, h, a})
    `CHK(masterSmbusSlow, s)
    `CHK(slaveSmbusAddr, SADDR_BASE | {1'b0, a[3], 1'b0, a[2:0], 1'b0})
    `CHK(gpioForceInput, 1'b0)
  endtask

  initial begin
    sys_clk = 1'b0;
    clkEn = 1'b1;
    lockDelay = 8'h03;
    {resetn, fundResetInN, warmResetRequestBit, hotResetRequestBit, upHotTs1Rx, upDlDown,
     linkdownHotResetDisable, hotResetEepromSkip, haltAfterReset, masterSmbusSlowSelect,
     haltClear, errInject, operatingModePins, slaveSmbusAddrPins} = '0;
    cyc(6);
    resetn = 1'b1;
    boot(MODE_NORMAL, 1'b1, 1'b0, 4'ha);
    `CHK({stackCfgRetry, eepromLoadDone, eeStarts}, 34'h0)
    // Pins moved before warm request
    {operatingModePins, masterSmbusSlowSelect} = {MODE_EEPROM, 1'b0};
    pulse(warmResetRequestBit);
    settle();
    `CHK(cpls, 1)
    `CHK({bootStatus, bootEeMode}, 10'h054)
    clkEn = 1'b0;
    pulse(warmResetRequestBit);
    cyc(2);
    `CHK({coreRstN, cpls}, 33'h1_0000_0001)
    clkEn = 1'b1;
    lockDelay = 8'h10;
    boot(MODE_EEPROM, 1'b0, 1'b0, 4'h5);
    `CHK({eepromLoadDone, haltCtlBit, bootEeMode}, 3'b101)
    `CHK(bootMode, MODE_EEPROM)
    `CHK(retrains, 1)
    pulse(hotResetRequestBit);
    settle();
    `CHK(cpls, 2)
    `CHK(eeStarts, 2)
    {linkdownHotResetDisable, upDlDown} = 2'b11;
    cyc(6);
    `CHK({coreRstN, hots}, 33'h1_0000_0001)
    {upDlDown, hotResetEepromSkip, haltAfterReset, upHotTs1Rx} = 4'b0111;
    cyc(6);
    `CHK({dsHotResetTs1, regHotHold, coreRstN, stickyRstN, pllSerdesRstN}, 5'b11011)
    upHotTs1Rx = 1'b0;
    settle();
    `CHK({hots, eeStarts, haltCtlBit}, 65'h4_0000_0004)
    {linkdownHotResetDisable, haltAfterReset} = 2'b00;
    pulse(upDlDown);
    settle();
    `CHK(hots, 3)
    {errInject, hotResetEepromSkip} = 2'b10;
    boot(MODE_EEPROM, 1'b0, 1'b0, 4'h3);
    `CHK({haltCtlBit, eeAccessEn, coreRstN, eepromLoadDone}, 4'b1101)
    `CHK(eeErrStatus, 8'h5a)
    errInject = 1'b0;
    pulse(haltClear);
    settle();
    `CHK({eeAccessEn, coreRstN}, 2'b01)
    boot(MODE_NORMAL, 1'b0, 1'b1, 4'h0);
    `CHK({haltStsBit, haltCtlBit, eeAccessEn}, 3'b111)
    haltAfterReset = 1'b0;
    pulse(haltClear);
    settle();
    // Reserved mode with slow lock: training on expiry
    lockDelay = 8'hff;
    operatingModePins = 3'h5;
    fundResetInN = 1'b0;
    cyc(4);
    fundResetInN = 1'b1;
    cyc(70);
    `CHK({linkTrainEn, stackRstN}, 2'b10)
    summarize();
  end
endmodule
